// ---- common/gdcfp_pkg.sv ----
package gdcfp_pkg;
   localparam int unsigned CLK_FREQ_HZ      = 10_000_000;
   localparam int unsigned CLK_PERIOD_NS    = 1_000_000_000 / CLK_FREQ_HZ;
   localparam int unsigned PHASES           = 3;
   // times as printed
   localparam int unsigned DEAD_TIME_NS     = 1_500;
   localparam int unsigned MIN_PULSE_NS     = 500;
   localparam int unsigned MAX_CARRIER_HZ   = 20_000;
   localparam int unsigned SHUTDOWN_MAX_US  = 5_000;
   localparam int unsigned RESTART_WAIT_MS  = 2_000;
   // cycle counts: least times round up, longest round down
   localparam int unsigned DEAD_CYC         = (DEAD_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MIN_PULSE_CYC    = (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned MIN_PERIOD_CYC   = (CLK_FREQ_HZ + MAX_CARRIER_HZ - 1) / MAX_CARRIER_HZ;
   localparam int unsigned SHUTDOWN_MAX_CYC = SHUTDOWN_MAX_US * (CLK_FREQ_HZ / 1_000_000);
   localparam longint unsigned RESTART_CYC  = longint'(RESTART_WAIT_MS) * (CLK_FREQ_HZ / 1_000);
   localparam int unsigned CNT_W            = 32;
   // fault handling states, one-hot
   typedef enum logic [2:0] {
      GDC_RUN   = 3'b001,
      GDC_TRIP  = 3'b010,
      GDC_WAIT  = 3'b100
   } gdc_state_t;
endpackage : gdcfp_pkg

// ---- logic/gdcfp_ctrl.sv ----
// Summary of operation
// - controller inserts at least 1.5 us dead time
// - each high and low pulse at least 0.5 us; the first pulse after a stop or after enable rises can be shorter
// - carrier at or below 20 kHz
// - commands always actively driven
// - on fault, drive all commands inactive
// - shutdown within worst-case 5 ms hold
// - wait two seconds before restarting drive
// - stop commands on abnormal sensed temperature

module gdcfp_ctrl
   import gdcfp_pkg::*;
#(
   parameter int unsigned PERIOD_CYC  = 500,
   parameter int unsigned DEAD_CYCLES = DEAD_CYC,
   parameter int unsigned MIN_PULSE   = MIN_PULSE_CYC,
   parameter int unsigned RESTART     = 32'(RESTART_CYC)
) (
   input  wire logic               CLK_IN,
   input  wire logic               RST_N_IN,
   input  wire logic               ENABLE_IN,
   input  wire logic [PHASES-1:0]  DUTY_HIGH_IN [0:0],
   input  wire logic [CNT_W-1:0]   DUTY_CYC_IN,
   input  wire logic               OVERHEAT_IN,
   input  wire logic               FAULT_OUTPUT_N_IN,
   output logic      [PHASES-1:0]  HIGH_SIDE_COMMAND_OUT,
   output logic      [PHASES-1:0]  LOW_SIDE_COMMAND_OUT,
   output logic                    FAULT_SEEN_OUT,
   output logic                    RUNNING_OUT
);
   // carrier never faster than 20 kHz; clamp the programmed period
   localparam int unsigned PERIOD = (PERIOD_CYC < MIN_PERIOD_CYC) ? MIN_PERIOD_CYC : PERIOD_CYC;
   // shortest legal on time per side: pulse floor plus one dead time
   localparam int unsigned DUTY_MIN = MIN_PULSE + DEAD_CYCLES;
   localparam int unsigned DUTY_MAX = PERIOD - MIN_PULSE - DEAD_CYCLES;

   // last count of each counter, so compares stay one width
   localparam int unsigned PERIOD_LAST  = PERIOD - 1;
   localparam int unsigned DEAD_LAST    = DEAD_CYCLES - 1;
   localparam int unsigned RESTART_LAST = RESTART - 1;

   typedef struct packed {
      gdc_state_t             state;

      // two-stage synchronisers for the asynchronous pins
      logic [1:0]             fault_sync;
      logic                   heat_sync0;
      logic                   heat_sync1;

      // carrier, latched on-time and restart timer
      logic [CNT_W-1:0]       carrier;
      logic [CNT_W-1:0]       duty;
      logic [CNT_W-1:0]       wait_cnt;

      // per phase wanted level, dead-time counters and commands
      logic [PHASES-1:0]      phase_want;
      logic [PHASES-1:0][CNT_W-1:0] dead;
      logic [PHASES-1:0]      hi;
      logic [PHASES-1:0]      lo;

      // status
      logic                   fault_seen;
      logic                   running;
   } gdc_regs_t;

   // whole state of the block in one register
   gdc_regs_t r_reg;
   gdc_regs_t r_next;

   // zero keeps a phase on its low side for the whole period
   function automatic logic [CNT_W-1:0] clamp_duty(input logic [CNT_W-1:0] d);
      if (d == '0) begin
         return '0;
      end else if (d < CNT_W'(DUTY_MIN)) begin
         return CNT_W'(DUTY_MIN);
      end else if (d > CNT_W'(DUTY_MAX)) begin
         return CNT_W'(DUTY_MAX);
      end else begin
         return d;
      end
   endfunction

   // wanted level of one phase inside the carrier period
   function automatic logic phase_level(input logic             high_first,
                                        input logic [CNT_W-1:0] cnt,
                                        input logic [CNT_W-1:0] on_time);
      if (high_first) begin
         return cnt < on_time;
      end else begin
         return cnt >= CNT_W'(PERIOD) - on_time;
      end
   endfunction

   // any reason to hold every command of every phase off
   function automatic logic hold_off(input gdc_state_t st,
                                     input logic       stop,
                                     input logic       enable);
      return stop || st != GDC_RUN || !enable;
   endfunction

   logic fault_now;
   logic stop_now;

   always_comb begin
      r_next = r_reg;

      // first stage feeds only the second stage
      r_next.fault_sync = {r_reg.fault_sync[0], FAULT_OUTPUT_N_IN};

      // overheat flag gets the same two stages
      r_next.heat_sync0 = OVERHEAT_IN;
      r_next.heat_sync1 = r_reg.heat_sync0;

      // both protections stop drive the same way
      fault_now = !r_reg.fault_sync[1];
      stop_now  = fault_now || r_reg.heat_sync1;

      // carrier and duty latched at period start so a duty change never cuts a pulse short
      if (r_reg.carrier >= CNT_W'(PERIOD_LAST)) begin
         r_next.carrier = '0;
         r_next.duty    = clamp_duty(DUTY_CYC_IN);
      end else begin
         r_next.carrier = r_reg.carrier + 1'b1;
      end

      for (int p = 0; p < PHASES; p++) begin
         // registered one cycle ahead of the commands
         r_next.phase_want[p] = phase_level(DUTY_HIGH_IN[0][p], r_reg.carrier, r_reg.duty);
      end

      // fault handling: RUN, then TRIP for one cycle, then WAIT
      case (r_reg.state)
         GDC_RUN: begin
            // enable alone never clears a latched fault
            r_next.running = ENABLE_IN;
            if (stop_now) begin
               r_next.state      = GDC_TRIP;
               r_next.fault_seen = 1'b1;
               r_next.running    = 1'b0;
            end
         end

         GDC_TRIP: begin
            // commands already forced low below; start restart timer
            r_next.state    = GDC_WAIT;
            r_next.wait_cnt = '0;
         end

         GDC_WAIT: begin
            // timer restarts while the fault or overheat persists
            // counted from the last clearance, never from the trip
            if (stop_now) begin
               r_next.wait_cnt = '0;
            end else if (r_reg.wait_cnt >= CNT_W'(RESTART_LAST)) begin
               r_next.state      = GDC_RUN;
               r_next.fault_seen = 1'b0;
            end else begin
               r_next.wait_cnt = r_reg.wait_cnt + 1'b1;
            end
         end

         default: begin
            r_next.state = GDC_TRIP;
         end
      endcase

      // dead-time per phase: a side may rise only after the other has been low DEAD cycles
      for (int p = 0; p < PHASES; p++) begin
         // a stop drops both sides at once, so no dead time is needed there
         if (hold_off(r_reg.state, stop_now, ENABLE_IN)) begin
            r_next.hi[p]   = 1'b0;
            r_next.lo[p]   = 1'b0;
            r_next.dead[p] = '0;
         end else if (r_reg.phase_want[p] != r_reg.hi[p] && (r_reg.hi[p] || r_reg.lo[p])) begin
            r_next.hi[p]   = 1'b0;
            r_next.lo[p]   = 1'b0;
            r_next.dead[p] = '0;
         end else if (!r_reg.hi[p] && !r_reg.lo[p]) begin
            // both sides low long enough; follow the wanted level
            if (r_reg.dead[p] >= CNT_W'(DEAD_LAST)) begin
               r_next.hi[p] = r_reg.phase_want[p];
               r_next.lo[p] = !r_reg.phase_want[p];
            end else begin
               r_next.dead[p] = r_reg.dead[p] + 1'b1;
            end
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
      if (!RST_N_IN) begin
         r_reg            <= '0;
         r_reg.state      <= GDC_RUN;
         // fault line idles high; a zero here would look like a trip
         r_reg.fault_sync <= 2'b11;
      end else begin
         r_reg <= r_next;
      end
   end

   // always driven, never released
   assign HIGH_SIDE_COMMAND_OUT = r_reg.hi;
   assign LOW_SIDE_COMMAND_OUT  = r_reg.lo;
   // status for the rest of the system
   assign FAULT_SEEN_OUT        = r_reg.fault_seen;
   assign RUNNING_OUT           = r_reg.running;

endmodule // gdcfp_ctrl

// ---- verification/gdcfp_ctrl_sva.sv ----
module gdcfp_ctrl_chk
   import gdcfp_pkg::*;
(
   input wire logic              CLK_IN,
   input wire logic              RST_N_IN,
   input wire logic              OVERHEAT_IN,
   input wire logic              FAULT_OUTPUT_N_IN,
   input wire logic [PHASES-1:0] HIGH_SIDE_COMMAND_OUT,
   input wire logic [PHASES-1:0] LOW_SIDE_COMMAND_OUT,
   input wire logic              FAULT_SEEN_OUT
);
   wire [2:0] hs = HIGH_SIDE_COMMAND_OUT;
   wire [2:0] ls = LOW_SIDE_COMMAND_OUT;
   wire       off = ~|{hs, ls};
   default clocking @(posedge CLK_IN); endclocking
   default disable iff (!RST_N_IN);
   no_overlap_a: assert property ((hs & ls) == 3'h0) else $error("both sides on");
   fault_stop_a: assert property (!FAULT_OUTPUT_N_IN |-> ##[1:3] off) else $error("no stop on fault");
   held_off_a: assert property (FAULT_SEEN_OUT |-> off) else $error("drive during wait");
   heat_stop_a: assert property (OVERHEAT_IN |-> ##[1:3] off) else $error("no stop on heat");
   seen_flag_a: assert property ((!FAULT_OUTPUT_N_IN)[*4] |-> FAULT_SEEN_OUT) else $error("fault not seen");
   sync_delay_a: assert property ($fell(FAULT_OUTPUT_N_IN) && !FAULT_SEEN_OUT |=> !FAULT_SEEN_OUT)
      else $error("fault used unsynced");
   dead_high_a: assert property ($fell(hs[0]) |-> (!ls[0])[*8] ##1 (!ls[0])[*7]) else $error("dead time");
   dead_low_a: assert property ($fell(ls[0]) |-> (!hs[0])[*8] ##1 (!hs[0])[*7]) else $error("dead time");
   // a fault may cut a pulse short
   min_pulse_a: assert property ($rose(hs[0]) |-> hs[0][*5] or ##[1:4] off) else $error("short pulse");
endmodule // gdcfp_ctrl_chk

bind gdcfp_ctrl gdcfp_ctrl_chk chk (.CLK_IN, .RST_N_IN, .OVERHEAT_IN, .FAULT_OUTPUT_N_IN,
   .HIGH_SIDE_COMMAND_OUT, .LOW_SIDE_COMMAND_OUT, .FAULT_SEEN_OUT);

// ---- verification/gdcfp_dev_model.sv ----
module gdcfp_dev_model #(
   parameter int HOLD  = 200,
   parameter int BLANK = 4
) (
   input  wire logic       clk_in,
   input  wire logic       trip_in,
   input  wire logic [2:0] hi_in,
   input  wire logic [2:0] lo_in,
   output logic            fault_n_out,
   output logic      [2:0] hi_gate_out,
   output logic      [2:0] lo_gate_out
);
   timeunit 1ns;
   timeprecision 1ns;
   int         hold_cnt  = 0;
   int         blank_cnt = 0;
   logic       oc_act;
   logic [2:0] hi_cmd;
   logic [2:0] lo_cmd;
   logic [2:0] hi_last   = 3'h0;
   logic [2:0] hi_gate   = 3'h0;
   // no supply lockout is exercised by these scenarios
   logic [2:0] boot_lock = 3'h0;
   // a floating or unknown command reads as off
   assign hi_cmd = {hi_in[2] === 1'b1, hi_in[1] === 1'b1, hi_in[0] === 1'b1};
   assign lo_cmd = {lo_in[2] === 1'b1, lo_in[1] === 1'b1, lo_in[0] === 1'b1};
   // shunt must stay above threshold for the whole blanking span
   always @(posedge clk_in) blank_cnt <= trip_in ? blank_cnt + 1 : 0;
   assign oc_act = trip_in && blank_cnt >= BLANK;
   // hold scaled down from the real millisecond figure
   always @(posedge clk_in) hold_cnt <= oc_act ? HOLD : (hold_cnt > 0 ? hold_cnt - 1 : 0);
   assign fault_n_out = !(oc_act || hold_cnt > 0);
   assign lo_gate_out = lo_cmd & {3{fault_n_out}};
   // upper gate follows command edges; lockout clears it and raises no fault
   always @(posedge clk_in) begin
      hi_last <= hi_cmd;
      hi_gate <= ~boot_lock & ((hi_gate | (hi_cmd & ~hi_last)) & ~(~hi_cmd & hi_last));
   end
   assign hi_gate_out = hi_gate;
endmodule // gdcfp_dev_model

// ---- verification/gdcfp_ctrl_tb.sv ----
module gdcfp_ctrl_tb;
   import gdcfp_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic              CLK_IN = 0, RST_N_IN = 0, ENABLE_IN = 0, OVERHEAT_IN = 0, trip = 0;
   logic [PHASES-1:0] DUTY_HIGH_IN [0:0] = '{3'h5};
   logic [CNT_W-1:0]  DUTY_CYC_IN = 32'h64;
   wire               FAULT_OUTPUT_N_IN, FAULT_SEEN_OUT, RUNNING_OUT;
   wire [PHASES-1:0]  HIGH_SIDE_COMMAND_OUT, LOW_SIDE_COMMAND_OUT;
   int                num_errors = 0, checks = 0, cyc = 0, n;
   gdcfp_ctrl #(.RESTART(100)) uut (.CLK_IN, .RST_N_IN, .ENABLE_IN, .DUTY_HIGH_IN, .DUTY_CYC_IN,
      .OVERHEAT_IN, .FAULT_OUTPUT_N_IN, .HIGH_SIDE_COMMAND_OUT, .LOW_SIDE_COMMAND_OUT, .FAULT_SEEN_OUT, .RUNNING_OUT);
   gdcfp_dev_model dev (.clk_in(CLK_IN), .trip_in(trip), .hi_in(HIGH_SIDE_COMMAND_OUT), .lo_in(LOW_SIDE_COMMAND_OUT),
      .fault_n_out(FAULT_OUTPUT_N_IN), .hi_gate_out(), .lo_gate_out());
   initial forever #50 CLK_IN = ~CLK_IN;
   function automatic logic idle();
      return (HIGH_SIDE_COMMAND_OUT | LOW_SIDE_COMMAND_OUT) === 3'h0;
   endfunction
   task automatic chk(input logic ok, input string msg);
      checks++;
      if (ok !== 1'b1) begin
         num_errors++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask
   task automatic complete_run;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge CLK_IN) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         complete_run();
      end
   end
   task automatic t_run;
      ENABLE_IN <= 1'b1;
      n = 0;
      while (n < 1200 && (HIGH_SIDE_COMMAND_OUT === 3'h0 || LOW_SIDE_COMMAND_OUT === 3'h0)) begin
         @(posedge CLK_IN);
         n++;
      end
      #1 chk(n < 1200 && RUNNING_OUT === 1'b1, "no drive");
      chk(!$isunknown({HIGH_SIDE_COMMAND_OUT, LOW_SIDE_COMMAND_OUT}), "floating command");
   endtask
   task automatic t_fault;
      @(posedge CLK_IN) trip <= 1'b1;
      repeat (8) @(posedge CLK_IN);
      #1 chk(idle() && FAULT_SEEN_OUT === 1'b1, "no stop on fault");
      @(posedge CLK_IN) trip <= 1'b0;
      n = 9;
      while (n < 400 && FAULT_SEEN_OUT !== 1'b0) begin
         @(posedge CLK_IN);
         n++;
      end
      // trip 9 cycles incl. blanking, 200 hold cycles, then 100 wait cycles
      chk(n >= 309 && n <= 316, "restart wait length");
      repeat (1200) @(posedge CLK_IN);
      chk(!idle(), "no resume after wait");
   endtask
   task automatic t_heat;
      @(posedge CLK_IN) OVERHEAT_IN <= 1'b1;
      repeat (4) @(posedge CLK_IN);
      #1 chk(idle(), "no stop on heat");
      @(posedge CLK_IN) OVERHEAT_IN <= 1'b0;
      repeat (60) @(posedge CLK_IN);
      #1 chk(idle(), "early restart after heat");
   endtask
   initial begin
      repeat (20) @(posedge CLK_IN);
      RST_N_IN <= 1'b1;
      t_run();
      t_fault();
      t_heat();
      complete_run();
   end
endmodule // gdcfp_ctrl_tb
